// >>> rtl/scr_chan.sv
// Package of shared constants and types, and one relay channel with cross-monitoring
package scr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int RESTART_MS = 500;
    // Restart delay stays strictly below the limit: one cycle short
    localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000) - 1;
    localparam int XMON_MS = 20;
    localparam int XMON_CYC = XMON_MS * (CLK_HZ / 1000);
    localparam int SW_COUNT = 3;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic loop_a;
        logic loop_b;
        logic actuated;
        logic reset_closed;
        logic fb_a;
        logic fb_b;
    } scr_sense_t;

    localparam scr_sense_t SENSE_RST = '{loop_a: 1'b0, loop_b: 1'b0, actuated: 1'b1,
                                         reset_closed: 1'b1, fb_a: 1'b0, fb_b: 1'b0};

    typedef enum logic [1:0] {
        ST_SAFE,
        ST_DELAY,
        ST_RUN
    } scr_state_t;

    typedef struct packed {
        logic relay;
        logic fault;
        logic [CNT_W-1:0] mis_cnt;
    } scr_chan_t;
endpackage

module scr_chan #(
    parameter int P_XMON_CYC = scr_pkg::XMON_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_enable,
    input wire logic i_own_fb,
    input wire logic i_other_fb,
    output logic o_relay,
    output logic o_fault
);
    import scr_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (P_XMON_CYC < 1)
    begin : g_bad_xmon
        $error("scr_chan: P_XMON_CYC must be at least 1");
    end

    scr_chan_t st_ff;
    scr_chan_t nxt_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        // Watch the other channel's relay against our own
        if (i_own_fb != i_other_fb)
        begin
            if (st_ff.mis_cnt >= CNT_W'(P_XMON_CYC - 1))
            begin
                nxt_st.fault = 1'b1;
            end
            else
            begin
                nxt_st.mis_cnt = st_ff.mis_cnt + CNT_ONE;
            end
        end
        else
        begin
            nxt_st.mis_cnt = CNT_ZERO;
            nxt_st.fault = 1'b0;
        end
        nxt_st.relay = i_enable & ~nxt_st.fault;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_ff <= '{relay: 1'b0, fault: 1'b0, mis_cnt: CNT_ZERO};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_relay = st_ff.relay;
    assign o_fault = st_ff.fault;
endmodule

// >>> rtl/scr_top.sv
// Dual-channel safety relay controller for a bridged contact sensor
// ------------------------------------------------------------
// Notes on behaviour
// - Two channels, each checks other's relay
// - Power indicator lit whenever supplied
// - Idle and reset: relays off, switching outputs open
// - Actuation or cable break: relays and switching outputs off
// - Signal output always inverse of switching
// - Two sensor loops; either open breaks
// - Manual: stay off until button pressed
// - Automatic: re-energise after restart delay
// - Reset stuck closed acts as automatic
// - Manual power-up: off until button
// - Reset never closed keeps relays off
// - Channel indicator follows its relay exactly
// - Restart delay below 500 ms
// ------------------------------------------------------------
module scr_top
    import scr_pkg::*;
#(
    parameter int P_RESTART_CYC = scr_pkg::RESTART_CYC,
    parameter int P_XMON_CYC = scr_pkg::XMON_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SENSOR_LOOP_A_IN,
    input wire logic I_SENSOR_LOOP_B_IN,
    input wire logic I_SENSOR_ACTUATED,
    input wire logic I_RESET_CLOSED,
    input wire logic I_RELAY_A_FB,
    input wire logic I_RELAY_B_FB,
    output logic O_SENSOR_LOOP_A_OUT,
    output logic O_SENSOR_LOOP_B_OUT,
    output logic O_RELAY_CHANNEL_A,
    output logic O_RELAY_CHANNEL_B,
    output logic O_LED_POWER,
    output logic O_LED_CHANNEL_A,
    output logic O_LED_CHANNEL_B,
    output logic [scr_pkg::SW_COUNT-1:0] O_SAFETY_SWITCHING_OUTPUT,
    output logic O_SIGNAL_OUT
);
    import scr_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (P_RESTART_CYC < 1 || P_RESTART_CYC >= RESTART_MS * (CLK_HZ / 1000))
    begin : g_bad_restart
        $error("scr_top: P_RESTART_CYC must be at least 1 and below the limit");
    end
    if (P_XMON_CYC < 1)
    begin : g_bad_xmon
        $error("scr_top: P_XMON_CYC must be at least 1");
    end

    typedef struct packed {
        scr_sense_t sync1;
        scr_sense_t sync2;
        logic reset_prev;
        scr_state_t state;
        logic [CNT_W-1:0] delay_cnt;
        logic power_led;
        logic loop_drive;
        logic both_on;
        logic sig_closed;
    } scr_top_t;

    localparam scr_top_t TOP_RST = '{
        sync1: SENSE_RST,
        sync2: SENSE_RST,
        reset_prev: 1'b1,
        state: ST_SAFE,
        delay_cnt: CNT_ZERO,
        power_led: 1'b1,
        loop_drive: 1'b1,
        both_on: 1'b0,
        sig_closed: 1'b1
    };

    scr_top_t st_ff;
    scr_top_t nxt_st;
    scr_sense_t raw;
    logic relay_a;
    logic relay_b;
    logic fault_a;
    logic fault_b;
    logic run_req;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Any condition that forbids the relays from being energised
    function automatic logic trip_cond(input scr_sense_t s, input logic fa, input logic fb);
        logic broken;
        broken = ~s.loop_a | ~s.loop_b;
        return broken | s.actuated | fa | fb;
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    always_comb
    begin
        raw.loop_a = I_SENSOR_LOOP_A_IN;
        raw.loop_b = I_SENSOR_LOOP_B_IN;
        raw.actuated = I_SENSOR_ACTUATED;
        raw.reset_closed = I_RESET_CLOSED;
        raw.fb_a = I_RELAY_A_FB;
        raw.fb_b = I_RELAY_B_FB;
    end

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    always_comb
    begin
        logic trip;
        logic reset_edge;
        trip = 1'b1;
        reset_edge = 1'b0;
        nxt_st = st_ff;
        nxt_st.sync1 = raw;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.reset_prev = st_ff.sync2.reset_closed;
        nxt_st.power_led = 1'b1;
        nxt_st.loop_drive = 1'b1;
        trip = trip_cond(st_ff.sync2, fault_a, fault_b);
        // A fresh closing of the reset input is a button press
        reset_edge = st_ff.sync2.reset_closed & ~st_ff.reset_prev;
        case (st_ff.state)
            ST_SAFE:
            begin
                nxt_st.delay_cnt = CNT_ZERO;
                if (!trip)
                begin
                    if (reset_edge)
                    begin
                        nxt_st.state = ST_RUN;
                    end
                    else if (st_ff.sync2.reset_closed)
                    begin
                        nxt_st.state = ST_DELAY;
                    end
                    else
                    begin
                        nxt_st.state = ST_SAFE;
                    end
                end
            end
            ST_DELAY:
            begin
                if (trip || !st_ff.sync2.reset_closed)
                begin
                    nxt_st.state = ST_SAFE;
                    nxt_st.delay_cnt = CNT_ZERO;
                end
                else if (st_ff.delay_cnt >= CNT_W'(P_RESTART_CYC - 1))
                begin
                    nxt_st.state = ST_RUN;
                    nxt_st.delay_cnt = CNT_ZERO;
                end
                else
                begin
                    nxt_st.delay_cnt = st_ff.delay_cnt + CNT_ONE;
                end
            end
            ST_RUN:
            begin
                if (trip)
                begin
                    nxt_st.state = ST_SAFE;
                end
            end
            default:
            begin
                nxt_st.state = ST_SAFE;
                nxt_st.delay_cnt = CNT_ZERO;
            end
        endcase
        // Switching outputs close only with both relays energised
        nxt_st.both_on = relay_a & relay_b & ~trip;
        // Signal output kept in its own flop, always the inverse
        nxt_st.sig_closed = ~nxt_st.both_on;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_ff <= TOP_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign run_req = (st_ff.state == ST_RUN) & ~trip_cond(st_ff.sync2, fault_a, fault_b);

    // ------------------------------------------------------------
    // Relay channels
    // ------------------------------------------------------------
    scr_chan #(
        .P_XMON_CYC(P_XMON_CYC)
    ) u_chan_a (
        .I_CLK(I_CLK),
        .I_RST(I_RST),
        .i_enable(run_req),
        .i_own_fb(st_ff.sync2.fb_a),
        .i_other_fb(st_ff.sync2.fb_b),
        .o_relay(relay_a),
        .o_fault(fault_a)
    );

    scr_chan #(
        .P_XMON_CYC(P_XMON_CYC)
    ) u_chan_b (
        .I_CLK(I_CLK),
        .I_RST(I_RST),
        .i_enable(run_req),
        .i_own_fb(st_ff.sync2.fb_b),
        .i_other_fb(st_ff.sync2.fb_a),
        .o_relay(relay_b),
        .o_fault(fault_b)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_RELAY_CHANNEL_A = relay_a;
    assign O_RELAY_CHANNEL_B = relay_b;
    assign O_LED_CHANNEL_A = relay_a;
    assign O_LED_CHANNEL_B = relay_b;
    assign O_LED_POWER = st_ff.power_led;
    assign O_SENSOR_LOOP_A_OUT = st_ff.loop_drive;
    assign O_SENSOR_LOOP_B_OUT = st_ff.loop_drive;
    assign O_SAFETY_SWITCHING_OUTPUT = {SW_COUNT{st_ff.both_on}};
    assign O_SIGNAL_OUT = st_ff.sig_closed;
endmodule

// >>> test/scr_monitor.sv
// Port checker for the dual-channel relay controller
module scr_monitor
    import scr_pkg::*;
#(
    parameter int P_RESTART_CYC = 20,
    parameter int P_XMON_CYC = 8
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SENSOR_LOOP_A_IN,
    input wire logic I_SENSOR_LOOP_B_IN,
    input wire logic I_SENSOR_ACTUATED,
    input wire logic I_RESET_CLOSED,
    input wire logic I_RELAY_A_FB,
    input wire logic I_RELAY_B_FB,
    input wire logic O_SENSOR_LOOP_A_OUT,
    input wire logic O_SENSOR_LOOP_B_OUT,
    input wire logic O_RELAY_CHANNEL_A,
    input wire logic O_RELAY_CHANNEL_B,
    input wire logic O_LED_POWER,
    input wire logic O_LED_CHANNEL_A,
    input wire logic O_LED_CHANNEL_B,
    input wire logic [scr_pkg::SW_COUNT-1:0] O_SAFETY_SWITCHING_OUTPUT,
    input wire logic O_SIGNAL_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    int mis_cnt;
    int ok_cnt;
    logic ok_now;
    logic off_now;
    assign ok_now = I_RESET_CLOSED && !I_SENSOR_ACTUATED && I_SENSOR_LOOP_A_IN
        && I_SENSOR_LOOP_B_IN && (I_RELAY_A_FB == I_RELAY_B_FB);
    assign off_now = !O_RELAY_CHANNEL_A && !O_RELAY_CHANNEL_B;
    always_ff @(posedge I_CLK)
    begin
        mis_cnt <= (I_RST || I_RELAY_A_FB == I_RELAY_B_FB) ? 0 : mis_cnt + 1;
        ok_cnt <= (I_RST || !ok_now) ? 0 : ok_cnt + 1;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_power_led_on: assert property (O_LED_POWER)
        else $error("power indicator dark");
    chk_led_a_relay: assert property (O_LED_CHANNEL_A == O_RELAY_CHANNEL_A)
        else $error("indicator A differs from relay A");
    chk_led_b_relay: assert property (O_LED_CHANNEL_B == O_RELAY_CHANNEL_B)
        else $error("indicator B differs from relay B");
    chk_signal_inverse: assert property (O_SIGNAL_OUT == !O_SAFETY_SWITCHING_OUTPUT[0])
        else $error("signal output not inverse");
    chk_switch_follow: assert property (O_SAFETY_SWITCHING_OUTPUT != '0 |->
        O_SAFETY_SWITCHING_OUTPUT == '1 && $past(O_RELAY_CHANNEL_A && O_RELAY_CHANNEL_B))
        else $error("switching outputs closed without both relays");
    chk_switch_close: assert property (O_RELAY_CHANNEL_A && O_RELAY_CHANNEL_B
        && $past(O_RELAY_CHANNEL_A && O_RELAY_CHANNEL_B) |-> O_SAFETY_SWITCHING_OUTPUT == '1)
        else $error("switching outputs open with both relays on");
    chk_loop_drive: assert property (O_SENSOR_LOOP_A_OUT && O_SENSOR_LOOP_B_OUT)
        else $error("sensor loop drive missing");
    chk_trip_drops: assert property (I_SENSOR_ACTUATED |-> ##[1:4] off_now)
        else $error("relays kept on after actuation");
    chk_loop_break: assert property (!(I_SENSOR_LOOP_A_IN && I_SENSOR_LOOP_B_IN)
        |-> ##[1:4] off_now)
        else $error("relays kept on after loop break");
    chk_rise_reset: assert property ($rose(O_RELAY_CHANNEL_A) |-> $past(I_RESET_CLOSED, 4))
        else $error("relay energised without reset");
    chk_restart_bound: assert property (ok_cnt == P_RESTART_CYC + 3
        |-> ##[0:4] (O_RELAY_CHANNEL_A && O_RELAY_CHANNEL_B))
        else $error("restart delay too long");
    chk_mismatch_trip: assert property (mis_cnt == P_XMON_CYC + 2 |-> ##[0:2] off_now)
        else $error("relay disagreement not tripped");
    cover property ($rose(O_RELAY_CHANNEL_A));
    cover property (ok_cnt == P_RESTART_CYC + 3);
    cover property (mis_cnt == P_XMON_CYC + 2);
endmodule

// >>> test/scr_far_model.sv
// Far side: relay readback, machine contactor and reset wiring
module scr_far_model (
    input wire logic i_clk,
    input wire logic i_relay_a,
    input wire logic i_relay_b,
    input wire logic i_sw_closed,
    input wire logic i_button,
    input wire logic i_weld_a,
    input wire logic i_drop_b,
    output logic o_fb_a = 1'b0,
    output logic o_fb_b = 1'b0,
    output logic o_reset_closed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic contactor_ff = 1'b0;
    always @(posedge i_clk)
    begin
        o_fb_a <= i_relay_a || i_weld_a;
        o_fb_b <= i_relay_b && !i_drop_b;
        contactor_ff <= i_sw_closed;
    end
    // Break contact of the contactor in series with button or bridge
    assign o_reset_closed = i_button && !contactor_ff;
endmodule

// >>> test/scr_top_tb_top.sv
// Scenario testbench for the relay controller
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module scr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import scr_pkg::*;
    localparam int P_RESTART_CYC = 20;
    localparam int P_XMON_CYC = 8;
    logic clk = 1'b0, rst = 1'b1, loop_a = 1'b1, loop_b = 1'b1, act = 1'b0;
    logic button = 1'b0, weld = 1'b0, drop = 1'b0, fb_a, fb_b, rst_cl, rl_a, rl_b;
    logic led_p, led_a, led_b, sig, lo_a, lo_b;
    logic [SW_COUNT-1:0] sw;
    int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
    scr_top #(.P_RESTART_CYC(P_RESTART_CYC), .P_XMON_CYC(P_XMON_CYC)) i_scr_top (
        .I_CLK(clk), .I_RST(rst), .I_SENSOR_LOOP_A_IN(loop_a), .I_SENSOR_LOOP_B_IN(loop_b),
        .I_SENSOR_ACTUATED(act), .I_RESET_CLOSED(rst_cl), .I_RELAY_A_FB(fb_a),
        .I_RELAY_B_FB(fb_b), .O_SENSOR_LOOP_A_OUT(lo_a), .O_SENSOR_LOOP_B_OUT(lo_b),
        .O_RELAY_CHANNEL_A(rl_a), .O_RELAY_CHANNEL_B(rl_b), .O_LED_POWER(led_p),
        .O_LED_CHANNEL_A(led_a), .O_LED_CHANNEL_B(led_b), .O_SAFETY_SWITCHING_OUTPUT(sw),
        .O_SIGNAL_OUT(sig));
    scr_far_model i_scr_far_model (.i_clk(clk), .i_relay_a(rl_a), .i_relay_b(rl_b),
        .i_sw_closed(sw[0]), .i_button(button), .i_weld_a(weld), .i_drop_b(drop),
        .o_fb_a(fb_a), .o_fb_b(fb_b), .o_reset_closed(rst_cl));
    initial
    begin
        forever #50 clk = !clk;
    end
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic press();
        button = 1'b1;
        cyc(10);
        button = 1'b0;
        cyc(4);
    endtask
    task automatic chk_out(input logic on);
        `CHK(rl_a, on)
        `CHK(rl_b, on)
        `CHK(led_a, on)
        `CHK(led_b, on)
        `CHK(sw, {3{on}})
        `CHK(sig, !on)
        `CHK(led_p, 1'b1)
        `CHK({lo_a, lo_b}, 2'b11)
    endtask
    task automatic t_powerup();
        cyc(30);
        chk_out(1'b0);
        press();
        chk_out(1'b1);
    endtask
    task automatic t_trip();
        act = 1'b1;
        cyc(10);
        chk_out(1'b0);
        act = 1'b0;
        cyc(30);
        chk_out(1'b0);
        press();
        chk_out(1'b1);
    endtask
    task automatic t_loops();
        for (int i = 0; i < 2; i++)
        begin
            {loop_a, loop_b} = (i == 0) ? 2'b01 : 2'b10;
            cyc(10);
            chk_out(1'b0);
            {loop_a, loop_b} = 2'b11;
            press();
            chk_out(1'b1);
        end
    endtask
    task automatic t_xmon();
        drop = 1'b1;
        cyc(P_XMON_CYC + 10);
        chk_out(1'b0);
        drop = 1'b0;
        press();
        chk_out(1'b1);
        weld = 1'b1;
        act = 1'b1;
        cyc(10);
        act = 1'b0;
        cyc(P_XMON_CYC);
        press();
        chk_out(1'b0);
        weld = 1'b0;
        cyc(10);
        press();
        chk_out(1'b1);
    endtask
    task automatic t_auto();
        int n;
        button = 1'b1;
        act = 1'b1;
        cyc(10);
        act = 1'b0;
        cyc(10);
        chk_out(1'b0);
        for (n = 0; n < P_RESTART_CYC + 20 && rl_a !== 1'b1; n++)
            @(negedge clk);
        `CHK(n + 10 >= P_RESTART_CYC, 1'b1)
        `CHK(n + 10 <= P_RESTART_CYC + 6, 1'b1)
        cyc(3);
        chk_out(1'b1);
        button = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        cyc(3);
        rst = 1'b0;
        t_powerup();
        t_trip();
        t_loops();
        t_xmon();
        t_auto();
        finish_test();
    end
endmodule
bind scr_top scr_monitor #(.P_RESTART_CYC(P_RESTART_CYC), .P_XMON_CYC(P_XMON_CYC))
    i_scr_monitor (.I_CLK, .I_RST, .I_SENSOR_LOOP_A_IN, .I_SENSOR_LOOP_B_IN,
    .I_SENSOR_ACTUATED, .I_RESET_CLOSED, .I_RELAY_A_FB, .I_RELAY_B_FB,
    .O_SENSOR_LOOP_A_OUT, .O_SENSOR_LOOP_B_OUT, .O_RELAY_CHANNEL_A,
    .O_RELAY_CHANNEL_B, .O_LED_POWER, .O_LED_CHANNEL_A, .O_LED_CHANNEL_B,
    .O_SAFETY_SWITCHING_OUTPUT, .O_SIGNAL_OUT);
